// ### pviu_top.sv
`timescale 1ns/1ps
module pviu_top (
  input wire logic clk,
  input wire logic rst_n,
  // External request pins, active low, asynchronous
  input wire logic ext0_pin_n,
  input wire logic ext1_pin_n,
  input wire logic ext0_type_sel,
  input wire logic ext1_type_sel,
  input wire logic timer0_ovf,
  input wire logic timer0_mode3,
  input wire logic timer1_ovf,
  input wire logic uart_receive_flag,
  input wire logic uart_transmit_flag,
  input wire logic spi_done_set,
  input wire logic [7:0] gp_flag_set,
  input wire logic comparator_set,
  input wire pviu_pkg::pviu_sw_wr_s sw,
  input wire logic [7:0] irq_enable_reg,
  input wire logic [7:0] priority_low_reg,
  input wire logic [7:0] priority_high_reg,
  input wire pviu_pkg::pviu_cpu_s cpu,
  output pviu_pkg::pviu_flags_s flags,
  output pviu_pkg::pviu_call_s call,
  output logic [3:0] in_service
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [1:0] pin_s1;
    logic [1:0] pin_s2;
    logic [1:0] pin_prev;
    pviu_pkg::pviu_flags_s flags;
    logic [6:0] req;
    logic [3:0] in_svc;
    logic [2:0] call_cnt;
    pviu_pkg::pviu_call_s call;
  } pviu_state_s;

  pviu_state_s state;
  pviu_state_s next_state;

  logic [1:0] rst_sync;
  logic rst_int_n;

  logic arb_found;
  logic [2:0] arb_src;
  logic [1:0] arb_level;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release

  // Assertion is immediate; release is aligned to clk by two stages
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  assign rst_int_n = rst_sync[1];

  ////////////////////////////////////////////////////////////////////////////
  // Arbitration over the sampled requests

  pviu_arbiter u_arbiter (
    .pending(state.req),
    .priority_low_reg(priority_low_reg),
    .priority_high_reg(priority_high_reg),
    .found(arb_found),
    .src(arb_src),
    .level(arb_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [1:0] pin_low;
    logic [1:0] pin_fall;
    logic [1:0] type_sel;
    logic [4:0] hw_set;
    logic [4:0] vec_clr;
    logic [6:0] raw;
    logic [6:0] en;
    logic busy;
    logic [1:0] cur;
    logic blocked;
    logic accept;
    logic [3:0] svc;

    next_state = state;
    pin_low = 2'h0;
    pin_fall = 2'h0;
    type_sel = {ext1_type_sel, ext0_type_sel};
    hw_set = 5'h00;
    vec_clr = 5'h00;
    raw = 7'h00;
    en = 7'h00;
    busy = 1'b0;
    cur = 2'h0;
    blocked = 1'b0;
    accept = 1'b0;
    svc = state.in_svc;

    // Pin synchroniser; first stage only feeds the second
    next_state.pin_s1 = {ext1_pin_n, ext0_pin_n};
    next_state.pin_s2 = state.pin_s1;
    next_state.pin_prev = state.pin_s2;
    pin_low = ~state.pin_s2;
    pin_fall = state.pin_prev & ~state.pin_s2;

    // Hardware set events
    hw_set[pviu_pkg::F_EXT0] = pin_fall[0];
    hw_set[pviu_pkg::F_EXT1] = pin_fall[1];
    hw_set[pviu_pkg::F_T0] = timer0_ovf && !timer0_mode3;
    hw_set[pviu_pkg::F_T1] = timer1_ovf;
    hw_set[pviu_pkg::F_CMP] = comparator_set;

    //////////////////////////////////////////////////////////////////////////
    // Acceptance at the instruction boundary

    busy = |state.in_svc;
    cur = pviu_pkg::top_level(state.in_svc);
    // Return or config write lets one more instruction run first
    blocked = cpu.instr_return_from_irq || cpu.instr_cfg_wr;
    accept = cpu.last_cycle && !blocked && arb_found &&
             (state.call_cnt == pviu_pkg::CALL_IDLE) &&
             (!busy || arb_level > cur);

    // Release the innermost level first, so a same-cycle accept stacks
    if (cpu.return_from_irq_done && busy) begin
      svc[cur] = 1'b0;
    end
    if (accept) begin
      svc[arb_level] = 1'b1;
    end
    next_state.in_svc = svc;

    // Auto-clear on vectoring: edge-mode pins and timers only
    if (accept) begin
      unique case (arb_src)
        pviu_pkg::SRC_EXT0: begin
          vec_clr[pviu_pkg::F_EXT0] = type_sel[0];
        end
        pviu_pkg::SRC_EXT1: begin
          vec_clr[pviu_pkg::F_EXT1] = type_sel[1];
        end
        pviu_pkg::SRC_T0: begin
          vec_clr[pviu_pkg::F_T0] = 1'b1;
        end
        pviu_pkg::SRC_T1: begin
          vec_clr[pviu_pkg::F_T1] = 1'b1;
        end
        // Serial, general and comparator flags stay set
        default: begin
          vec_clr = 5'h00;
        end
      endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // Flags: clears first, then sets, so a coincident set wins

    next_state.flags.hw = (state.flags.hw & ~vec_clr & ~sw.clr) |
                          sw.set | hw_set;
    // Level mode: the pin alone decides the flag
    if (!type_sel[0]) begin
      next_state.flags.hw[pviu_pkg::F_EXT0] = pin_low[0];
    end
    if (!type_sel[1]) begin
      next_state.flags.hw[pviu_pkg::F_EXT1] = pin_low[1];
    end

    // Hardware-only set, software-only clear
    next_state.flags.spi_done_flag =
      (state.flags.spi_done_flag && !sw.spi_clr) || spi_done_set;
    // A held level input keeps setting, so its clear cannot stick
    next_state.flags.general_input_flag_reg =
      (state.flags.general_input_flag_reg & ~sw.gp_clr) |
      gp_flag_set;

    //////////////////////////////////////////////////////////////////////////
    // Request sampling, one cycle behind the flags

    raw[pviu_pkg::SRC_EXT0] = state.flags.hw[pviu_pkg::F_EXT0];
    raw[pviu_pkg::SRC_T0] = state.flags.hw[pviu_pkg::F_T0];
    raw[pviu_pkg::SRC_EXT1] = state.flags.hw[pviu_pkg::F_EXT1];
    raw[pviu_pkg::SRC_T1] = state.flags.hw[pviu_pkg::F_T1];
    raw[pviu_pkg::SRC_SER] = uart_receive_flag || uart_transmit_flag ||
                             state.flags.spi_done_flag;
    raw[pviu_pkg::SRC_GP] = |state.flags.general_input_flag_reg;
    raw[pviu_pkg::SRC_CMP] = state.flags.hw[pviu_pkg::F_CMP];

    // Enable bits share positions with source indices
    en = irq_enable_reg[6:0] & {7{irq_enable_reg[pviu_pkg::EN_GLOBAL]}};
    // Fresh sample every cycle, nothing of a denied request is kept
    next_state.req = raw & en;

    //////////////////////////////////////////////////////////////////////////
    // Entry call sequencing

    next_state.call.start = accept;
    if (accept) begin
      next_state.call_cnt = pviu_pkg::CALL_CYCLES;
      next_state.call.src = arb_src;
      next_state.call.level = arb_level;
      next_state.call.addr = pviu_pkg::vec_addr(arb_src);
    end else if (state.call_cnt != pviu_pkg::CALL_IDLE) begin
      next_state.call_cnt = state.call_cnt - 3'h1;
    end
    next_state.call.active = (next_state.call_cnt != pviu_pkg::CALL_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      // Pins idle high so no false edge appears at release
      state.pin_s1 <= 2'h3;
      state.pin_s2 <= 2'h3;
      state.pin_prev <= 2'h3;
      state.flags <= '0;
      state.req <= 7'h00;
      state.in_svc <= 4'h0;
      state.call_cnt <= pviu_pkg::CALL_IDLE;
      state.call.start <= 1'b0;
      state.call.active <= 1'b0;
      state.call.src <= 3'h0;
      state.call.level <= 2'h0;
      state.call.addr <= pviu_pkg::VEC_RESET;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from state

  assign flags = state.flags;
  assign call = state.call;
  assign in_service = state.in_svc;

endmodule // pviu_top

// ### pviu_pkg.sv
// Contract
// - Seven sources: two pins, two timers, serial, general, comparator.
// - Own enable per source; cleared global enable blocks every source.
// - All but comparator take one of four levels from two registers.
// - Comparator is always at the lowest level, never programmable.
// - Preemption only by strictly higher level; top level never preempted.
// - Higher pending level is serviced first at an instruction boundary.
// - Within one level the lowest vector address wins; ties only.
// - Pin request is level or edge by a type bit; its flag drives it.
// - Vectoring clears a pin pending flag only in edge mode.
// - Timer flags set on rollover, except timer zero in its mode 3.
// - Vectoring to a timer routine clears that timer flag.
// - Serial request is OR of receive, transmit, SPI done; none cleared.
// - General request is OR of eight flag bits; software clears them.
// - Comparator flag drives its request and survives vectoring.
// - Software set or clear of most flags acts like hardware.
// - SPI done and general flags: hardware sets, software only clears.
// - Fixed vectors 0000, 0003, 000B, 0013, 001B, 0023, 002B, 0033 hex.
// - Poll at instruction end uses prior-cycle flags; denials are forgotten.
// - Equal or higher level busy, return or config write: no vectoring.
// - The entry call lasts four cycles and is the next instruction.
// - Two-bit level is high-register bit over low-register bit.
package pviu_pkg;

  localparam int NUM_SRC = 7;
  localparam int NUM_LVL = 4;
  localparam int NUM_GP = 8;

  // Source index equals vector order
  localparam logic [2:0] SRC_EXT0 = 3'h0;
  localparam logic [2:0] SRC_T0 = 3'h1;
  localparam logic [2:0] SRC_EXT1 = 3'h2;
  localparam logic [2:0] SRC_T1 = 3'h3;
  localparam logic [2:0] SRC_SER = 3'h4;
  localparam logic [2:0] SRC_GP = 3'h5;
  localparam logic [2:0] SRC_CMP = 3'h6;

  // Bits of the software set/clear masks and the flag vector
  localparam int F_EXT0 = 0;
  localparam int F_T0 = 1;
  localparam int F_EXT1 = 2;
  localparam int F_T1 = 3;
  localparam int F_CMP = 4;
  localparam int NUM_FLAG = 5;

  // Global enable position in the enable register
  localparam int EN_GLOBAL = 7;
  localparam logic [1:0] CMP_LEVEL = 2'h0;

  localparam logic [15:0] VEC_RESET = 16'h0000;
  localparam logic [15:0] VEC_EXT0 = 16'h0003;
  localparam logic [15:0] VEC_T0 = 16'h000b;
  localparam logic [15:0] VEC_EXT1 = 16'h0013;
  localparam logic [15:0] VEC_T1 = 16'h001b;
  localparam logic [15:0] VEC_SER = 16'h0023;
  localparam logic [15:0] VEC_GP = 16'h002b;
  localparam logic [15:0] VEC_CMP = 16'h0033;

  localparam logic [2:0] CALL_CYCLES = 3'h4;
  localparam logic [2:0] CALL_IDLE = 3'h0;

  typedef struct packed {
    logic last_cycle;
    logic instr_return_from_irq;
    logic instr_cfg_wr;
    logic return_from_irq_done;
  } pviu_cpu_s;

  typedef struct packed {
    logic [NUM_FLAG-1:0] set;
    logic [NUM_FLAG-1:0] clr;
    logic spi_clr;
    logic [NUM_GP-1:0] gp_clr;
  } pviu_sw_wr_s;

  typedef struct packed {
    logic [NUM_FLAG-1:0] hw;
    logic spi_done_flag;
    logic [NUM_GP-1:0] general_input_flag_reg;
  } pviu_flags_s;

  typedef struct packed {
    logic start;
    logic active;
    logic [2:0] src;
    logic [1:0] level;
    logic [15:0] addr;
  } pviu_call_s;

  function automatic logic [15:0] vec_addr(input logic [2:0] src);
    logic [15:0] a;
    a = VEC_RESET;
    unique case (src)
      SRC_EXT0: a = VEC_EXT0;
      SRC_T0: a = VEC_T0;
      SRC_EXT1: a = VEC_EXT1;
      SRC_T1: a = VEC_T1;
      SRC_SER: a = VEC_SER;
      SRC_GP: a = VEC_GP;
      SRC_CMP: a = VEC_CMP;
      default: a = VEC_RESET;
    endcase
    return a;
  endfunction

  // Innermost (highest) level present in an in-service mask
  function automatic logic [1:0] top_level(input logic [3:0] mask);
    logic [1:0] t;
    t = 2'h0;
    for (int i = 0; i < NUM_LVL; i++) begin
      if (mask[i]) begin
        t = 2'(i);
      end
    end
    return t;
  endfunction

endpackage

// ### pviu_arbiter.sv
`timescale 1ns/1ps
module pviu_arbiter (
  input wire logic [6:0] pending,
  input wire logic [7:0] priority_low_reg,
  input wire logic [7:0] priority_high_reg,
  output logic found,
  output logic [2:0] src,
  output logic [1:0] level
);

  always_comb begin
    logic [1:0] lv;
    lv = 2'h0;
    found = 1'b0;
    src = 3'h0;
    level = 2'h0;
    // Descending scan lets the lower vector win a tie
    for (int i = pviu_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (i == int'(pviu_pkg::SRC_CMP)) begin
        lv = pviu_pkg::CMP_LEVEL;
      end else begin
        lv = {priority_high_reg[i], priority_low_reg[i]};
      end
      if (pending[i] && (!found || lv >= level)) begin
        found = 1'b1;
        src = 3'(i);
        level = lv;
      end
    end
  end

endmodule // pviu_arbiter

// ### pviu_monitor.sv
`timescale 1ns/1ps
module pviu_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic timer0_ovf,
  input wire logic timer0_mode3,
  input wire logic [7:0] irq_enable_reg,
  input wire pviu_pkg::pviu_sw_wr_s sw,
  input wire pviu_pkg::pviu_cpu_s cpu,
  input wire pviu_pkg::pviu_flags_s flags,
  input wire pviu_pkg::pviu_call_s call,
  input wire logic [3:0] in_service
);
  // Internal reset trails rst_n by two edges, so input checks wait for it
  logic [1:0] up;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      up <= 2'h0;
    end else begin
      up <= {up[0], 1'h1};
    end
  end
  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  //////////////////////////////////////////////////////////////////////////
  AST_CALL_LEN: assert property (
    $rose(call.active) |-> call.start ##0 call.active[*4] ##1 !call.active)
    else $error("entry call length wrong");
  AST_BLOCKED: assert property (
    call.start |-> $past(cpu.last_cycle && !cpu.instr_return_from_irq
      && !cpu.instr_cfg_wr)) else $error("accept outside a legal boundary");
  AST_GLOBAL: assert property (
    call.start |-> $past(irq_enable_reg[7], 2))
    else $error("accept with global enable off");
  AST_VECTOR: assert property (
    call.start |-> call.src != 3'h7 && call.addr == {10'h000, call.src, 3'h3})
    else $error("vector address wrong");
  AST_CMP_LEVEL: assert property (
    call.start && call.src == 3'h6 |-> call.level == 2'h0)
    else $error("comparator not at lowest level");
  AST_IN_SERVICE: assert property (
    call.start |-> in_service[call.level])
    else $error("accepted level not marked in service");
  AST_PREEMPT: assert property (
    call.start && !$past(cpu.return_from_irq_done)
      |-> ($past(in_service) >> call.level) == 4'h0)
    else $error("preemption without strictly higher level");
  AST_T0_CLEAR: assert property (
    call.start && call.src == 3'h1 && !$past(timer0_ovf)
      && !$past(sw.set[1]) |-> !flags.hw[1])
    else $error("timer flag kept through vectoring");
  AST_T0_SET: assert property (
    up[1] && timer0_ovf && !timer0_mode3 |=> flags.hw[1])
    else $error("timer flag not set on rollover");
endmodule // pviu_monitor

bind pviu_top pviu_monitor mon (.clk(clk), .rst_n(rst_n),
  .timer0_ovf(timer0_ovf), .timer0_mode3(timer0_mode3),
  .irq_enable_reg(irq_enable_reg), .sw(sw), .cpu(cpu), .flags(flags),
  .call(call), .in_service(in_service));

// ### pviu_cpu_model.sv
`timescale 1ns/1ps
module pviu_cpu_model (
  input wire logic clk,
  input wire logic run,
  input wire logic return_from_irq,
  input wire logic cfg,
  input wire logic ret,
  input wire pviu_pkg::pviu_call_s call,
  output pviu_pkg::pviu_cpu_s cpu
);
  logic odd = 1'h0;
  // Two-cycle instructions; the core stalls while the entry call runs
  always @(posedge clk) begin
    odd <= run && !call.active && !odd;
    cpu.last_cycle <= run && !call.active && odd;
    cpu.instr_return_from_irq <= return_from_irq;
    cpu.instr_cfg_wr <= cfg;
    cpu.return_from_irq_done <= ret;
  end
endmodule // pviu_cpu_model

// ### tb_pviu_top.sv
`timescale 1ns/1ps
module tb_pviu_top;
  logic clk = 1'h0, rst_n = 1'h0, p0_n = 1'h1, p1_n = 1'h1;
  logic s0 = 1'h0, s1 = 1'h0, t0 = 1'h0, m3 = 1'h0, t1 = 1'h0, rx = 1'h0;
  logic tx = 1'h0, spi = 1'h0, cmp = 1'h0, run = 1'h0, return_from_irq = 1'h0;
  logic cfg = 1'h0, ret = 1'h0;
  logic [7:0] gp = 8'h00, en = 8'h00, pl = 8'h00, ph = 8'h00;
  logic [3:0] in_service;
  pviu_pkg::pviu_sw_wr_s sw = '0;
  pviu_pkg::pviu_cpu_s cpu;
  pviu_pkg::pviu_flags_s flags;
  pviu_pkg::pviu_call_s call;
  int bad_count = 0, comparisons = 0;
  localparam logic [15:0] vt [7] = '{16'h0003, 16'h000b, 16'h0013,
    16'h001b, 16'h0023, 16'h002b, 16'h0033};
  always #5 clk = ~clk;
  pviu_top dut (
    .clk(clk), .rst_n(rst_n), .ext0_pin_n(p0_n), .ext1_pin_n(p1_n),
    .ext0_type_sel(s0), .ext1_type_sel(s1), .timer0_ovf(t0),
    .timer0_mode3(m3), .timer1_ovf(t1), .uart_receive_flag(rx),
    .uart_transmit_flag(tx), .spi_done_set(spi), .gp_flag_set(gp),
    .comparator_set(cmp), .sw(sw), .irq_enable_reg(en),
    .priority_low_reg(pl), .priority_high_reg(ph), .cpu(cpu),
    .flags(flags), .call(call), .in_service(in_service));
  pviu_cpu_model cpu_model (.clk(clk), .run(run), .return_from_irq(return_from_irq),
    .cfg(cfg), .ret(ret), .call(call), .cpu(cpu));
  //////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic swp(input logic [4:0] s, c);
    sw.set = s;
    sw.clr = c;
    tick(1);
    sw = '0;
  endtask
  // Bounded wait for an accept, then judge what it carries
  task automatic exp_call(input logic [2:0] s, input logic [1:0] l);
    int k;
    int n;
    k = 0;
    n = 0;
    while (call.start !== 1'h1 && k < 40) begin
      tick(1);
      k++;
    end
    if (call.start !== 1'h1) begin
      chk("call_start", 16'h1, 16'h0);
      end_sim();
    end else begin
      chk("src", 16'(s), 16'(call.src));
      chk("addr", vt[s], call.addr);
      chk("level", 16'(l), 16'(call.level));
      chk("in_service", 16'h1, 16'(in_service[l]));
      repeat (6) begin
        n += int'(call.active === 1'h1);
        tick(1);
      end
      chk("active", 16'h4, 16'(n));
    end
  endtask
  task automatic exp_none(input int n);
    int k;
    k = 0;
    repeat (n) begin
      k += int'(call.start === 1'h1);
      tick(1);
    end
    chk("no_call", 16'h0, 16'(k));
  endtask
  // Return pulse; what follows may vector at once, so no check here
  task automatic rel();
    ret = 1'h1;
    tick(1);
    ret = 1'h0;
    tick(2);
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic s_timer();
    en = 8'h82;
    {m3, t0} = 2'h3;
    tick(1);
    t0 = 1'h0;
    exp_none(12);
    chk("t0_flag", 16'h0, 16'(flags.hw[1]));
    m3 = 1'h0;
    t0 = 1'h1;
    tick(1);
    t0 = 1'h0;
    exp_call(3'h1, 2'h0);
    chk("t0_flag", 16'h0, 16'(flags.hw[1]));
    rel();
    chk("in_service", 16'h0, 16'(in_service));
  endtask
  task automatic s_global();
    {pl, ph} = 16'h3f3f;
    cmp = 1'h1;
    tick(1);
    cmp = 1'h0;
    en = 8'h40;
    exp_none(8);
    en = 8'hbf;
    exp_none(8);
    en = 8'hc0;
    exp_call(3'h6, 2'h0);
    chk("cmp_flag", 16'h1, 16'(flags.hw[4]));
    swp(5'h00, 5'h10);
    chk("cmp_flag", 16'h0, 16'(flags.hw[4]));
    rel();
  endtask
  task automatic s_prio();
    en = 8'h8a;
    {pl, ph} = 16'h0808;
    swp(5'h0a, 5'h00);
    exp_call(3'h3, 2'h3);
    exp_none(12);
    rel();
    exp_call(3'h1, 2'h0);
    swp(5'h08, 5'h00);
    exp_call(3'h3, 2'h3);
    chk("in_service", 16'h9, 16'(in_service));
    rel();
    chk("in_service", 16'h1, 16'(in_service));
    rel();
  endtask
  task automatic s_tie();
    {pl, ph} = 16'h0a00;
    {t0, t1} = 2'h3;
    tick(1);
    {t0, t1} = 2'h0;
    exp_call(3'h1, 2'h1);
    exp_none(12);
    rel();
    exp_call(3'h3, 2'h1);
    chk("t1_flag", 16'h0, 16'(flags.hw[3]));
    rel();
  endtask
  task automatic s_pins();
    en = 8'h85;
    {pl, s0} = 9'h001;
    p0_n = 1'h0;
    exp_call(3'h0, 2'h0);
    chk("ext0_flag", 16'h0, 16'(flags.hw[0]));
    p0_n = 1'h1;
    rel();
    p1_n = 1'h0;
    exp_call(3'h2, 2'h0);
    chk("ext1_flag", 16'h1, 16'(flags.hw[2]));
    p1_n = 1'h1;
    tick(6);
    chk("ext1_flag", 16'h0, 16'(flags.hw[2]));
    rel();
  endtask
  task automatic s_serial();
    en = 8'hb0;
    {rx, tx} = 2'h3;
    exp_call(3'h4, 2'h0);
    {rx, tx, spi, gp} = 11'h180;
    tick(1);
    {spi, gp} = 9'h000;
    chk("spi_flag", 16'h1, 16'(flags.spi_done_flag));
    rel();
    exp_call(3'h4, 2'h0);
    sw.spi_clr = 1'h1;
    tick(1);
    sw = '0;
    rel();
    exp_call(3'h5, 2'h0);
    chk("gp_flag", 16'h80, 16'(flags.general_input_flag_reg));
    sw.gp_clr = 8'h80;
    tick(1);
    sw = '0;
    chk("gp_flag", 16'h0, 16'(flags.general_input_flag_reg));
    rel();
  endtask
  task automatic s_block();
    en = 8'h82;
    for (int i = 0; i < 2; i++) begin
      {cfg, return_from_irq} = 2'(i + 1);
      swp(5'h02, 5'h00);
      exp_none(12);
      {cfg, return_from_irq} = 2'h0;
      exp_call(3'h1, 2'h0);
      rel();
    end
    en = 8'h02;
    swp(5'h02, 5'h00);
    tick(8);
    swp(5'h00, 5'h02);
    en = 8'h82;
    exp_none(12);
  endtask
  initial begin
    tick(16);
    rst_n = 1'h1;
    tick(4);
    run = 1'h1;
    s_timer();
    s_global();
    s_prio();
    s_tie();
    s_pins();
    s_serial();
    s_block();
    end_sim();
  end
endmodule // tb_pviu_top
